// ---- mcs_main_clock.sv ----
/*
 * Main clock source select, clock status and X1 settle control.
 * Assumes a byte-wide memory access port in the clk domain, stop events
 * as one-cycle pulses from the CPU, and an asynchronous X1 clock pin.
 */
`default_nettype none

module mcs_main_clock
    import mcs_pkg::*;
#(
    parameter int unsigned SETTLE_SHIFT = 0
) (
    input wire logic clk,
    input wire logic rst,
    input wire mcs_bus_s bus,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic x1_pin,
    input wire logic stop_exec,
    input wire logic stop_release,
    input wire logic hs_oscillator_stop,
    input wire logic hs_osc_stop_set,
    output mcs_clk_sel_s clk_sel,
    output logic cpu_hold
);

    typedef struct packed {
        logic main_source_select;
        logic peripheral_source_select;
        logic periph_locked;
        logic main_source_status;
        logic [2:0] settle_code;
        logic [7:0] rd_data;
        logic rd_valid;
        mcs_sw_e sw;
        logic [3:0] gap_cnt;
        logic int_en;
        logic ext_en;
        logic stopped;
        logic post_stop;
        logic hold;
        logic [2:0] x1_sync;
    } mcs_state_s;

    mcs_state_s st;
    mcs_state_s next_st;
    logic [4:0] settle_flags;
    logic settle_reached;
    logic settle_clear;
    logic desired_ext;
    logic x1_edge;
    logic [SETTLE_W-1:0] settle_cap;

    // ----------------------------------------------------------------
    // Derived terms
    // ----------------------------------------------------------------
    // Main clock may only go external when the peripheral side is external
    assign desired_ext = st.peripheral_source_select & st.main_source_select;
    assign x1_edge = st.x1_sync[1] & ~st.x1_sync[2];
    assign settle_clear = stop_exec | hs_osc_stop_set;
    // Before any stop the counter runs to the longest wait
    assign settle_cap = st.post_stop ? (settle_limit(st.settle_code) >> SETTLE_SHIFT)
                                     : (SETTLE_2E16 >> SETTLE_SHIFT);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.x1_sync = {st.x1_sync[1:0], x1_pin};
        next_st.rd_valid = bus.rd;
        next_st.rd_data = 8'h00;
        // Register reads; unmapped addresses return zero
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_MAIN_SEL: next_st.rd_data = {5'h00, st.peripheral_source_select,
                                                  st.main_source_status,
                                                  st.main_source_select};
                ADDR_SETTLE_STAT: next_st.rd_data = {3'h0, settle_flags};
                ADDR_SETTLE_SEL: next_st.rd_data = {5'h00, st.settle_code};
                default: next_st.rd_data = 8'h00;
            endcase
        end
        // Mode register: byte or bit writes; status bit is never written
        if (bus.addr == ADDR_MAIN_SEL && (bus.wr || bus.bit_wr)) begin
            if (bus.wr || bus.bit_sel == BIT_MAIN_SRC) begin
                next_st.main_source_select = bus.wr ? bus.data[BIT_MAIN_SRC] : bus.bit_val;
            end
            if ((bus.wr || bus.bit_sel == BIT_PERIPH_SRC) && !st.periph_locked) begin
                next_st.peripheral_source_select = bus.wr ? bus.data[BIT_PERIPH_SRC]
                                                          : bus.bit_val;
                // First real change locks the bit until the next reset
                next_st.periph_locked = (next_st.peripheral_source_select
                                         != st.peripheral_source_select);
            end
        end
        // Settle select takes byte writes only; prohibited codes are stored as
        // written and decode to the longest wait
        if (bus.addr == ADDR_SETTLE_SEL && bus.wr) begin
            next_st.settle_code = bus.data[2:0];
        end
        // Stop sequencing and the post-stop hold
        if (stop_exec) begin
            next_st.stopped = 1'b1;
        end
        if (stop_release) begin
            next_st.stopped = 1'b0;
            next_st.post_stop = 1'b1;
            next_st.hold = st.main_source_status;
        end else if (st.hold && settle_reached && !st.stopped) begin
            next_st.hold = 1'b0;
        end
        if (hs_osc_stop_set) begin
            next_st.post_stop = 1'b0;
        end
        // Break-before-make main clock switch; status moves only with the
        // new enable so software never sees a source that is not yet live
        unique case (st.sw)
            SW_IDLE: begin
                if (desired_ext != st.main_source_status) begin
                    next_st.int_en = 1'b0;
                    next_st.ext_en = 1'b0;
                    next_st.gap_cnt = 4'(SWITCH_GAP_CYC);
                    next_st.sw = SW_GAP;
                end
            end
            SW_GAP: begin
                if (st.gap_cnt > 4'h1) begin
                    next_st.gap_cnt = st.gap_cnt - 4'h1;
                end else begin
                    next_st.int_en = ~desired_ext;
                    next_st.ext_en = desired_ext;
                    next_st.main_source_status = desired_ext;
                    next_st.sw = SW_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.main_source_select <= MAIN_SEL_RST[BIT_MAIN_SRC];
            st.peripheral_source_select <= MAIN_SEL_RST[BIT_PERIPH_SRC];
            st.main_source_status <= MAIN_SEL_RST[BIT_MAIN_STAT];
            st.settle_code <= SETTLE_SEL_RST;
            st.int_en <= 1'b1;
            st.sw <= SW_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Settle counter
    // ----------------------------------------------------------------
    // The oscillator is dead while stopped, so nothing is counted then
    mcs_settle_counter #(
        .SHIFT(SETTLE_SHIFT)
    ) u_settle (
        .clk(clk),
        .rst(rst),
        .clear(settle_clear),
        .run(!st.stopped && !hs_oscillator_stop),
        .x1_edge(x1_edge),
        .cap(settle_cap),
        .flags(settle_flags),
        .reached(settle_reached)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Watchdog and low-speed timer clocks are not routed here at all
    assign clk_sel.main_int_en = st.int_en;
    assign clk_sel.main_ext_en = st.ext_en;
    assign clk_sel.periph_ext = st.peripheral_source_select;
    assign clk_sel.capture_ext = st.peripheral_source_select;
    assign rd_data = st.rd_data;
    assign rd_valid = st.rd_valid;
    assign cpu_hold = st.hold;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_main_int: assert property (disable iff (1'b0)
        rst |=> !clk_sel.periph_ext && clk_sel.main_int_en && !st.main_source_status)
        else $error("reset did not select the internal clock");
    a_reset_settle_sel: assert property (disable iff (1'b0)
        rst |=> st.settle_code == SETTLE_SEL_RST)
        else $error("settle select reset value wrong");
    a_periph_int_main: assert property (
        !st.peripheral_source_select && st.sw == SW_IDLE |-> !clk_sel.main_ext_en)
        else $error("main clock external while peripheral select is internal");
    a_periph_once: assert property (
        st.periph_locked |=> $stable(st.peripheral_source_select))
        else $error("peripheral select changed twice");
    a_no_overlap: assert property (
        !(clk_sel.main_int_en && clk_sel.main_ext_en))
        else $error("both main clock enables active");
    a_status_follows: assert property (
        $changed(st.main_source_status) |-> clk_sel.main_ext_en == st.main_source_status)
        else $error("status changed without the new source live");
    a_status_ro: assert property (
        st.sw == SW_IDLE && bus.wr && bus.addr == ADDR_MAIN_SEL |=>
        st.main_source_status == $past(st.main_source_status))
        else $error("write changed the main status bit");
    a_stop_clears: assert property (
        stop_exec |=> settle_flags == SETTLE_STAT_RST)
        else $error("stop did not clear settle status");
    a_hold_release: assert property (
        st.hold && settle_reached && !st.stopped && !stop_release |=> !cpu_hold)
        else $error("hold not released after settle wait");
    a_gap_length: assert property (
        st.sw == SW_IDLE ##1 st.sw == SW_GAP |-> (!st.int_en && !st.ext_en) [*3])
        else $error("switch gap too short");

    c_switch_ext: cover property ($rose(st.main_source_status));
    c_all_flags: cover property (settle_flags == 5'h1f);
    c_hold_done: cover property ($fell(st.hold));

endmodule : mcs_main_clock

`default_nettype wire

// ---- mcs_main_clock_tb.sv ----
/*
 * Self-checking bench for mcs_main_clock: bus tasks, read queue, X1 model.
 * Assumes mcs_pkg, the design files and mcs_x1_osc are compiled first.
 */
`default_nettype none

module mcs_main_clock_tb import mcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned SH = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mcs_bus_s bus = '0;
    logic [7:0] rd_data;
    logic rd_valid, x1, cpu_hold;
    logic stop_exec = 1'b0, stop_release = 1'b0, osc_stop = 1'b0, osc_stop_set = 1'b0;
    logic x1_run = 1'b0;
    mcs_clk_sel_s clk_sel;
    int unsigned edges, base;
    int errors = 0, tests_run = 0;
    logic [7:0] exp_q[$];
    int unsigned pts[5] = '{12, 40, 80, 160, 300};

    // --------------------------------------------------------------
    // Clock, design and far side
    // --------------------------------------------------------------
    // Free-running 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    mcs_main_clock #(.SETTLE_SHIFT(SH)) i_mcs_main_clock (.clk(clk), .rst(rst), .bus(bus),
        .rd_data(rd_data), .rd_valid(rd_valid), .x1_pin(x1), .stop_exec(stop_exec),
        .stop_release(stop_release), .hs_oscillator_stop(osc_stop),
        .hs_osc_stop_set(osc_stop_set), .clk_sel(clk_sel), .cpu_hold(cpu_hold));
    mcs_x1_osc i_mcs_x1_osc (.run(x1_run & ~osc_stop), .x1(x1), .edges(edges));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        // A read still queued at the end never got its answer
        if (exp_q.size() != 0) begin
            chk("reads pending", 8'h00, 8'(exp_q.size()));
        end
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Kind is {rd, wr, bit_wr}; a bit write carries {value, bit number} in data
    task automatic acc(input logic [2:0] kind, input logic [15:0] addr, input logic [7:0] data);
        cyc(1);
        {bus.rd, bus.wr, bus.bit_wr} = kind;
        bus.addr = addr;
        bus.data = data;
        bus.bit_sel = data[2:0];
        bus.bit_val = data[3];
        cyc(1);
        {bus.rd, bus.wr, bus.bit_wr} = 3'h0;
    endtask : acc

    task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        acc(3'h4, addr, 8'h00);
    endtask : rd

    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    task automatic wait_edges(input int unsigned n);
        int k = 0;
        while (edges - base < n && k < 20000) begin
            @(posedge clk);
            k++;
        end
        #1;
        // Running out of patience counts as a mismatch
        if (k >= 20000) begin
            chk("x1 edge wait", 8'h00, 8'h01);
        end
    endtask : wait_edges

    function automatic int unsigned cap_of(input int k);
        return ((k == 1) ? 2048 : (2048 << k)) >> SH;
    endfunction : cap_of

    function automatic logic [7:0] sel_now();
        return {4'h0, clk_sel.main_int_en, clk_sel.main_ext_en, clk_sel.periph_ext,
            clk_sel.capture_ext};
    endfunction : sel_now

    // Read answers stand one cycle; sampled mid-cycle to stay clear of the edge
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unrequested read", 8'h00, 8'h01);
            end else begin
                chk("rd_data", exp_q.pop_front(), rd_data);
            end
        end
    end

    // Hang guard, far beyond the roughly 25 us the sequence needs
    initial begin
        #200000;
        errors++;
        print_verdict();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        int n;
        logic [7:0] e;
        void'($urandom(56789));
        cyc(6);
        rst = 1'b0;
        chk("sel reset", 8'h08, sel_now());
        rd(ADDR_MAIN_SEL, 8'h00);
        rd(ADDR_SETTLE_SEL, 8'h05);
        rd(ADDR_SETTLE_STAT, 8'h00);
        rd(16'hffa2, 8'h00);
        acc(3'h2, ADDR_SETTLE_STAT, 8'($urandom));
        acc(3'h1, ADDR_SETTLE_SEL, 8'h09);
        rd(ADDR_SETTLE_SEL, 8'h05);
        rd(ADDR_SETTLE_STAT, 8'h00);
        // Flags climb one by one, counted from the first X1 edge
        x1_run = 1'b1;
        base = edges;
        for (int i = 0; i < 5; i++) begin
            wait_edges(pts[i]);
            e = 8'h00;
            for (int j = 1; j <= 5; j++) begin
                if (pts[i] >= cap_of(j)) e[5-j] = 1'b1;
            end
            rd(ADDR_SETTLE_STAT, e);
        end
        // Switch to external with a dead gap between the two enables
        acc(3'h2, ADDR_MAIN_SEL, 8'h05);
        // Peripheral side moves with the write, main enable drops one edge later
        chk("periph first", 8'h0a, sel_now() & 8'h0e);
        cyc(1);
        chk("gap start", 8'h02, sel_now() & 8'h0e);
        cyc(2);
        chk("gap end", 8'h02, sel_now() & 8'h0e);
        cyc(1);
        chk("sel external", 8'h07, sel_now());
        rd(ADDR_MAIN_SEL, 8'h07);
        acc(3'h2, ADDR_MAIN_SEL, 8'h01);
        acc(3'h1, ADDR_MAIN_SEL, 8'h01);
        rd(ADDR_MAIN_SEL, 8'h07);
        acc(3'h1, ADDR_MAIN_SEL, 8'h00);
        cyc(5);
        chk("sel main internal", 8'h0b, sel_now());
        rd(ADDR_MAIN_SEL, 8'h04);
        acc(3'h1, ADDR_MAIN_SEL, 8'h08);
        cyc(5);
        // Stop with X1 driving the CPU, every wait code in turn
        for (int k = 1; k <= 5; k++) begin
            acc(3'h2, ADDR_SETTLE_SEL, 8'(k));
            rd(ADDR_SETTLE_SEL, 8'(k));
            pulse(stop_exec);
            x1_run = 1'b0;
            rd(ADDR_SETTLE_STAT, 8'h00);
            cyc($urandom_range(20, 5));
            x1_run = 1'b1;
            base = edges;
            pulse(stop_release);
            chk("cpu_hold", 8'h01, {7'h0, cpu_hold});
            n = 0;
            while (cpu_hold === 1'b1 && n < 3000) begin
                cyc(1);
                n++;
            end
            chk("held edges", 8'h01, 8'(edges - base >= cap_of(k)
                && edges - base <= cap_of(k) + 2));
            wait_edges(cap_of(k) + 40);
            rd(ADDR_SETTLE_STAT, 8'(5'(5'h1f << (5 - k))));
        end
        // Internal CPU across stop: no hold; then oscillator stop clears status
        acc(3'h1, ADDR_MAIN_SEL, 8'h00);
        cyc(5);
        pulse(stop_exec);
        pulse(stop_release);
        chk("cpu_hold internal", 8'h00, {7'h0, cpu_hold});
        // Wait code 5 covers the two shortest flags that software checks here
        base = edges;
        wait_edges(40);
        rd(ADDR_SETTLE_STAT, 8'h18);
        osc_stop = 1'b1;
        pulse(osc_stop_set);
        rd(ADDR_SETTLE_STAT, 8'h00);
        cyc(200);
        rd(ADDR_SETTLE_STAT, 8'h00);
        // Second reset in mid-run unlocks the peripheral select again
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        chk("sel reset 2", 8'h08, sel_now());
        rd(ADDR_SETTLE_SEL, 8'h05);
        acc(3'h2, ADDR_MAIN_SEL, 8'h04);
        rd(ADDR_MAIN_SEL, 8'h04);
        cyc(4);
        print_verdict();
    end
endmodule : mcs_main_clock_tb

`default_nettype wire

// ---- mcs_pkg.sv ----
/*
 * Shared constants, types and decode functions for the main clock select
 * and oscillator settle counter block.
 * Assumes a single 250 MHz system clock and a synchronous active-high reset.
 */
`default_nettype none

package mcs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_MAIN_SEL = 16'hffa1;
    localparam logic [15:0] ADDR_SETTLE_STAT = 16'hffa3;
    localparam logic [15:0] ADDR_SETTLE_SEL = 16'hffa4;
    localparam logic [7:0] MAIN_SEL_RST = 8'h00;
    localparam logic [4:0] SETTLE_STAT_RST = 5'h00;
    localparam logic [2:0] SETTLE_SEL_RST = 3'h5;
    localparam logic [2:0] BIT_PERIPH_SRC = 3'h2;
    localparam logic [2:0] BIT_MAIN_STAT = 3'h1;
    localparam logic [2:0] BIT_MAIN_SRC = 3'h0;

    // ----------------------------------------------------------------
    // Settle wait encodings and X1 cycle counts
    // ----------------------------------------------------------------
    localparam int SETTLE_W = 17;
    localparam logic [SETTLE_W-1:0] SETTLE_2E11 = 17'h00800;
    localparam logic [SETTLE_W-1:0] SETTLE_2E13 = 17'h02000;
    localparam logic [SETTLE_W-1:0] SETTLE_2E14 = 17'h04000;
    localparam logic [SETTLE_W-1:0] SETTLE_2E15 = 17'h08000;
    localparam logic [SETTLE_W-1:0] SETTLE_2E16 = 17'h10000;

    // Dead time between dropping one main clock enable and raising the other
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SWITCH_GAP_PS = 12000;
    localparam int SWITCH_GAP_CYC = (SWITCH_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic bit_val;
        logic [15:0] addr;
        logic [7:0] data;
    } mcs_bus_s;

    typedef struct packed {
        logic main_int_en;
        logic main_ext_en;
        logic periph_ext;
        logic capture_ext;
    } mcs_clk_sel_s;

    typedef enum logic [0:0] {SW_IDLE, SW_GAP} mcs_sw_e;

    // Wait length for a select code; prohibited codes fall back to the longest
    function automatic logic [SETTLE_W-1:0] settle_limit(input logic [2:0] code);
        unique case (code)
            3'h1: settle_limit = SETTLE_2E11;
            3'h2: settle_limit = SETTLE_2E13;
            3'h3: settle_limit = SETTLE_2E14;
            3'h4: settle_limit = SETTLE_2E15;
            default: settle_limit = SETTLE_2E16;
        endcase
    endfunction : settle_limit

endpackage : mcs_pkg

`default_nettype wire

// ---- mcs_settle_counter.sv ----
/*
 * X1 oscillation settle counter with five sticky threshold flags.
 * Assumes x1_edge is a one-cycle pulse already synchronised to clk.
 */
`default_nettype none

module mcs_settle_counter
    import mcs_pkg::*;
#(
    parameter int unsigned SHIFT = 0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic run,
    input wire logic x1_edge,
    input wire logic [SETTLE_W-1:0] cap,
    output logic [4:0] flags,
    output logic reached
);

    typedef struct packed {
        logic [SETTLE_W-1:0] cnt;
        logic [4:0] flags;
    } mcs_cnt_state_s;

    mcs_cnt_state_s st;
    mcs_cnt_state_s next_st;
    logic [SETTLE_W-1:0] thr;

    // ----------------------------------------------------------------
    // Counting and flag update
    // ----------------------------------------------------------------
    // Counting only on real X1 edges keeps start-up time out of the wait
    always_comb begin
        next_st = st;
        thr = '0;
        if (clear) begin
            next_st = '0;
        end else if (run && x1_edge && st.cnt < cap) begin
            next_st.cnt = st.cnt + 17'h00001;
        end
        // Flag 4 is the shortest wait, flag 0 the longest
        for (int k = 0; k < 5; k++) begin
            thr = settle_limit(3'(k + 1)) >> SHIFT;
            if (!clear && next_st.cnt >= thr) begin
                next_st.flags[4-k] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
    assign reached = (st.cnt >= cap);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_flags_ordered: assert property (@(posedge clk) disable iff (rst)
        st.flags inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f})
        else $error("settle flags set out of order");
    a_flags_sticky: assert property (@(posedge clk) disable iff (rst)
        !clear |=> (st.flags & $past(st.flags)) == $past(st.flags))
        else $error("settle flag dropped without clear");
    a_count_capped: assert property (@(posedge clk) disable iff (rst)
        $stable(cap) && !clear |=> st.cnt <= cap || st.cnt == $past(st.cnt))
        else $error("settle count passed the cap");
    a_edge_counts: assert property (@(posedge clk) disable iff (rst)
        run && x1_edge && !clear && st.cnt < cap |=> st.cnt == $past(st.cnt) + 17'h00001)
        else $error("X1 edge not counted");

endmodule : mcs_settle_counter

`default_nettype wire

// ---- mcs_x1_osc.sv ----
/*
 * Behavioural X1 resonator model for the main clock select bench.
 * Assumes the bench lowers run during stop mode with X1 driving the CPU and while the oscillator is stopped.
 */
`default_nettype none

module mcs_x1_osc #(
    parameter realtime HALF_NS = 9.7,
    parameter realtime START_NS = 300.0
) (
    input wire logic run,
    output var logic x1,
    output var int unsigned edges
);
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------------
    // Oscillator
    // --------------------------------------------------------------
    // Start-up interval first, so a counter that counts it shows up early
    initial begin
        x1 = 1'b0;
        edges = 0;
        forever begin
            wait (run === 1'b1);
            #START_NS;
            while (run === 1'b1) begin
                #HALF_NS;
                x1 = 1'b1;
                edges++;
                #HALF_NS;
                x1 = 1'b0; // Pin rests low once stopped
            end
        end
    end
endmodule : mcs_x1_osc

`default_nettype wire
